/* File: core/imsc_map.vh */
`ifndef IMSC_MAP_VH
`define IMSC_MAP_VH
// register byte offsets
`define IMSC_OFS_RAW        12'h000
`define IMSC_OFS_MASKED     12'h004
`define IMSC_OFS_EN_SET     12'h008
`define IMSC_OFS_EN_CLEAR   12'h00c
`define IMSC_OFS_EVT_STAT   12'h010
`define IMSC_OFS_EVT_CLEAR  12'h014
`define IMSC_OFS_EVT_ENABLE 12'h018
`define IMSC_OFS_WAIT_CFG   12'h01c
// field positions and source count
`define IMSC_BIT_TIMEOUT    0
`define IMSC_BIT_LINE_TRAP  1
`define IMSC_BIT_WAIT_RISE  2
`define IMSC_NUM_SRC        3
`define IMSC_BIT_CFG_WAIT   0
// reset values and address width
`define IMSC_EN_RESET       3'h0
`define IMSC_ZERO32         32'h00000000
`define IMSC_ADDR_W         12
`endif

/* File: core/imsc_sync2.v */
`timescale 1ns/1ns
`default_nettype none
// two-flop synchroniser for one level
module imsc_sync2 (
  input  wire sys_clk,
  input  wire reset_n,
  input  wire asyncIn,
  output wire syncOut
);
  reg stage1;
  reg stage2;

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
    end else begin
      stage1 <= asyncIn;
      stage2 <= stage1;
    end
  end

  assign syncOut = stage2;
endmodule
`default_nettype wire

/* File: core/imsc_sticky.v */
`timescale 1ns/1ns
`default_nettype none
// sticky event bit: set wins over a same-cycle clear
module imsc_sticky (
  input  wire sys_clk,
  input  wire reset_n,
  input  wire setPulse,
  input  wire clearPulse,
  output reg  flag
);
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      flag <= 1'b0;
    end else if (setPulse) begin
      flag <= 1'b1;
    end else if (clearPulse) begin
      flag <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: core/imsc_interrupt_mask_set_clear.v */
`timescale 1ns/1ns
`default_nettype none
`include "imsc_map.vh"

module imsc_interrupt_mask_set_clear (
  input  wire        sys_clk,
  input  wire        reset_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire        hasWaitPin,
  input  wire        timeoutEvent,
  input  wire        lineTrapEvent,
  input  wire        waitRiseEvent,
  input  wire        externalWaitPin,
  output wire [2:0]  maskedStatus,
  output wire        timeoutMaskedStatus,
  output wire        maskedIrq,
  output wire        irq
);
  reg  [2:0]  enable;
  reg  [2:0]  evtEnable;
  reg         waitRiseOnPin;
  reg         waitPrev;
  wire        strapSync;
  wire [2:0]  rawFlag;
  wire [2:0]  setEvt;
  wire [2:0]  evtFlag;
  wire        waitSync;
  wire        waitRiseDet;
  wire        writeAcc;
  wire        regsLive;
  reg  [31:0] readMux;
  reg         addrHit;

  function is_offset;
    input [11:0] addr;
    input [11:0] ofs;
    begin
      is_offset = (addr == ofs);
    end
  endfunction

  // zero-wait slave: every access completes in its first access cycle
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~addrHit;
  assign writeAcc = psel & penable & pwrite & addrHit;

  // the variant strap is meant to be tied, but it is a pin all the same:
  // it passes a synchroniser, so it takes effect two cycles after reset
  imsc_sync2 u_strapSync (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .asyncIn (hasWaitPin),
    .syncOut (strapSync)
  );

  assign regsLive = strapSync;

  imsc_sync2 u_waitSync (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .asyncIn (externalWaitPin),
    .syncOut (waitSync)
  );

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      waitPrev <= 1'b0;
    end else begin
      waitPrev <= waitSync;
    end
  end

  assign waitRiseDet = waitSync & ~waitPrev & waitRiseOnPin;

  // raw flags: pin-derived wait-rise optional, external pulses otherwise
  assign setEvt[`IMSC_BIT_TIMEOUT]   = timeoutEvent;
  assign setEvt[`IMSC_BIT_LINE_TRAP] = lineTrapEvent;
  assign setEvt[`IMSC_BIT_WAIT_RISE] = waitRiseEvent | waitRiseDet;

  genvar g;
  generate
    for (g = 0; g < `IMSC_NUM_SRC; g = g + 1) begin : g_src
      imsc_sticky u_raw (
        .sys_clk    (sys_clk),
        .reset_n    (reset_n),
        .setPulse   (setEvt[g]),
        .clearPulse (writeAcc &
                     is_offset(paddr, `IMSC_OFS_RAW) & pwdata[g]),
        .flag       (rawFlag[g])
      );
      imsc_sticky u_evt (
        .sys_clk    (sys_clk),
        .reset_n    (reset_n),
        .setPulse   (setEvt[g]),
        .clearPulse (writeAcc &
                     is_offset(paddr, `IMSC_OFS_EVT_CLEAR) & pwdata[g]),
        .flag       (evtFlag[g])
      );
    end
  endgenerate

  // set/clear pair share one enable; a write of 0 leaves it alone
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      enable <= `IMSC_EN_RESET;
    end else if (writeAcc && regsLive) begin
      if (is_offset(paddr, `IMSC_OFS_EN_SET)) begin
        enable <= enable | pwdata[2:0];
      end else if (is_offset(paddr, `IMSC_OFS_EN_CLEAR)) begin
        enable <= enable & ~pwdata[2:0];
      end
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      evtEnable     <= `IMSC_EN_RESET;
      waitRiseOnPin <= 1'b0;
    end else if (writeAcc) begin
      if (is_offset(paddr, `IMSC_OFS_EVT_ENABLE)) begin
        evtEnable <= pwdata[2:0];
      end
      if (is_offset(paddr, `IMSC_OFS_WAIT_CFG)) begin
        waitRiseOnPin <= pwdata[`IMSC_BIT_CFG_WAIT];
      end
    end
  end

  assign maskedStatus        = rawFlag & enable;
  assign timeoutMaskedStatus = maskedStatus[`IMSC_BIT_TIMEOUT];
  assign maskedIrq           = |maskedStatus;
  assign irq                 = |(evtFlag & evtEnable);

  always @* begin
    addrHit = 1'b1;
    readMux = `IMSC_ZERO32;
    case (paddr)
      `IMSC_OFS_RAW:        readMux[2:0] = rawFlag;
      `IMSC_OFS_MASKED:     readMux[2:0] = maskedStatus;
      `IMSC_OFS_EN_SET:     readMux[2:0] = regsLive ? enable : 3'h0;
      `IMSC_OFS_EN_CLEAR:   readMux[2:0] = regsLive ? enable : 3'h0;
      `IMSC_OFS_EVT_STAT:   readMux[2:0] = evtFlag;
      `IMSC_OFS_EVT_CLEAR:  readMux[2:0] = 3'h0;
      `IMSC_OFS_EVT_ENABLE: readMux[2:0] = evtEnable;
      `IMSC_OFS_WAIT_CFG:   readMux[`IMSC_BIT_CFG_WAIT] = waitRiseOnPin;
      default:              addrHit      = 1'b0;
    endcase
  end

  // read data registered in the setup cycle so it is stable in access
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= `IMSC_ZERO32;
    end else if (psel && !penable && !pwrite) begin
      prdata <= readMux;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/imsc_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
`include "imsc_map.vh"
module imsc_monitor (
  input wire        sys_clk,
  input wire        reset_n,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire [31:0] prdata,
  input wire        pslverr,
  input wire        hasWaitPin,
  input wire [2:0]  maskedStatus,
  input wire        timeoutMaskedStatus,
  input wire        maskedIrq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire acc = psel && penable;
  wire enRd = acc && !pwrite && (paddr == `IMSC_OFS_EN_SET ||
              paddr == `IMSC_OFS_EN_CLEAR);
  sequence clrWr;
    acc && pwrite && paddr == `IMSC_OFS_EN_CLEAR;
  endsequence
  answer_now_a: assert property (pready) else $error("pready low");
  clr_drops_a: assert property (
    clrWr |=> (maskedStatus & $past(pwdata[2:0])) == 3'h0)
    else $error("cleared enable still unmasks");
  high_zero_a: assert property (
    enRd |-> prdata[31:3] == 29'h0) else $error("upper bits set");
  no_pin_a: assert property (
    enRd && !hasWaitPin |-> prdata == 32'h0) else $error("reserved read");
  bad_addr_a: assert property (acc && paddr > `IMSC_OFS_WAIT_CFG
    |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped accepted");
  ts_copy_a: assert property (
    timeoutMaskedStatus == maskedStatus[0]) else $error("timeout copy");
  irq_or_a: assert property (
    maskedIrq == |maskedStatus) else $error("masked irq wrong");
  rst_zero_a: assert property (
    $rose(reset_n) |-> maskedStatus == 3'h0) else $error("not reset");
endmodule
bind imsc_interrupt_mask_set_clear imsc_monitor mon (.*);
`default_nettype wire

/* File: testbench/tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "imsc_map.vh"
module tb;
  logic sys_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic hasWaitPin = 1, externalWaitPin = 0;
  logic timeoutEvent = 0, lineTrapEvent = 0, waitRiseEvent = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, q;
  logic err;
  wire pready, pslverr, timeoutMaskedStatus, maskedIrq, irq;
  wire [31:0] prdata;
  wire [2:0] maskedStatus;
  int n_fail = 0, total_checks = 0, cyc = 0;
  always #5 sys_clk = ~sys_clk;
  imsc_interrupt_mask_set_clear dut (.*);
  task conclude;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task check(input [31:0] s, input [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task xfer(input w, input [11:0] a, input [31:0] d);
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input [11:0] a, input [31:0] e);
    xfer(0, a, 0);
    check(q, e);
  endtask
  task rst(input p);
    hasWaitPin <= p;
    reset_n <= 0;
    repeat (4) @(posedge sys_clk);
    reset_n <= 1;
    repeat (2) @(posedge sys_clk);
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      conclude;
    end
  end
  initial begin
    rst(1);
    rd(`IMSC_OFS_EN_SET, 0);
    rd(`IMSC_OFS_EN_CLEAR, 0);
    check(err, 0);
    rd(12'h020, 0);
    check(err, 1);
    $display("test reset done");
    xfer(1, `IMSC_OFS_EN_SET, 7);
    rd(`IMSC_OFS_EN_CLEAR, 7);
    for (int i = 0; i < 3; i++) begin
      xfer(1, `IMSC_OFS_EN_CLEAR, 0);
      xfer(1, `IMSC_OFS_EN_CLEAR, 1 << i);
      rd(`IMSC_OFS_EN_SET, (7 << (i + 1)) & 7);
      rd(`IMSC_OFS_EN_CLEAR, (7 << (i + 1)) & 7);
    end
    $display("test enables done");
    @(posedge sys_clk);
    {waitRiseEvent, lineTrapEvent, timeoutEvent} <= 3'h7;
    @(posedge sys_clk);
    {waitRiseEvent, lineTrapEvent, timeoutEvent} <= 3'h0;
    @(negedge sys_clk);
    check(maskedIrq, 0);
    check(irq, 0);
    xfer(1, `IMSC_OFS_EN_SET, 7);
    @(negedge sys_clk);
    check(maskedStatus, 7);
    check(timeoutMaskedStatus, 1);
    rd(`IMSC_OFS_MASKED, 7);
    xfer(1, `IMSC_OFS_EN_CLEAR, 4);
    @(negedge sys_clk);
    check(maskedStatus, 3);
    xfer(1, `IMSC_OFS_EN_SET, 4);
    @(negedge sys_clk);
    check(maskedStatus, 7);
    xfer(1, `IMSC_OFS_EVT_ENABLE, 2);
    @(negedge sys_clk);
    check(irq, 1);
    xfer(1, `IMSC_OFS_EVT_CLEAR, 2);
    @(negedge sys_clk);
    check(irq, 0);
    rd(`IMSC_OFS_EVT_STAT, 5);
    rd(`IMSC_OFS_EVT_CLEAR, 0);
    xfer(1, `IMSC_OFS_RAW, 7);
    @(negedge sys_clk);
    check(maskedIrq, 0);
    xfer(1, `IMSC_OFS_WAIT_CFG, 1);
    rd(`IMSC_OFS_WAIT_CFG, 1);
    externalWaitPin <= 1;
    repeat (4) @(posedge sys_clk);
    rd(`IMSC_OFS_RAW, 4);
    check(maskedStatus, 4);
    $display("test events done");
    rst(0);
    xfer(1, `IMSC_OFS_EN_SET, 7);
    rd(`IMSC_OFS_EN_SET, 0);
    rd(`IMSC_OFS_EN_CLEAR, 0);
    {waitRiseEvent, lineTrapEvent, timeoutEvent} <= 3'h7;
    @(posedge sys_clk);
    {waitRiseEvent, lineTrapEvent, timeoutEvent} <= 3'h0;
    @(negedge sys_clk);
    check(maskedStatus, 0);
    $display("test no pin done");
    conclude;
  end
endmodule
`default_nettype wire
